/* File: core/sclt_irq_tree.v */
/*
 per-port event counters with one-second latching, event flags and the
 three-level interrupt tree behind an 8-bit synchronous register bus.
 assumes RD and WR are one-cycle strobes synchronous to MCLK.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sclt_map.vh"
// Functional notes
// - low-byte read freezes higher bytes to match the count at that time
// - each counter is wide enough for one second of events
// - reading a counter clears it to zero
// - status-latch enable makes status reads return last one-second state
// - counter-latch enable makes counter reads return last latched values
// - on one-second tick with latching, counter moves to latch and clears
// - reading a counter latch clears it
// - pin as output is the 8 kHz reference divided by 8000, mode bit 0
// - pin as input latches status and counters on its rising edge
// - single-event flags set on assertion, dual-event on both edges
// - transmit parity error sets tx flag bit 7, cleared on read
// - delineation loss and recovery set rx flag bit 7, cleared on read
// - each flag has an enable masking it from the next level
// - enabled rx and tx flags OR into the port summary bits
// - enabled port summary bits OR into the device port bit
// - enabled device bits drive the irq pin, gated by mode bit 3
// - summary layout: rx, tx, external, one-second; bits 4-7 reserved
// - reading a flag register returns all its bits to default
// - external and one-second clear on read; rx/tx follow their flags
// - device port bit clears only once port summary is all clear
// - the inverse-multiplexing section adds no interrupt sources
// - every register is 8 bits wide
module sclt_irq_tree #(
  parameter NPORT = 8,
  parameter CNT_W = `SCLT_CNT_W,
  parameter DIV = `SCLT_DIV_COUNT
) (
  input wire MCLK,
  input wire RSTN,
  input wire [9:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [8*NPORT-1:0] RX_STATUS,
  input wire [8*NPORT-1:0] TX_STATUS,
  input wire [NPORT-1:0] EXT_IRQ,
  input wire [NPORT-1:0] CELL_EVT,
  input wire FRAME_REF,
  input wire ONESEC_I,
  output wire ONESEC_O,
  output wire ONESEC_OE,
  output reg HOST_IRQ_N
);
  // ****************************************
  // decode helpers
  // ****************************************
  function port_hit;
    input [9:0] a;
    input [2:0] p;
    begin
      port_hit = !a[`SCLT_DEV_SPACE_BIT] && (a[8:6] == p);
    end
  endfunction

  // one register of one port; every per-port strobe goes through here
  function port_reg;
    input [9:0] a;
    input [2:0] p;
    input [5:0] o;
    begin
      port_reg = port_hit(a, p) && (a[5:0] == o);
    end
  endfunction

  wire [5:0] off = ADDR[5:0];
  wire [2:0] pidx = ADDR[8:6];
  wire [5:0] base = {pidx, 3'b000};

  // ****************************************
  // device mode and device summary enables
  // ****************************************
  reg [7:0] mode_q;
  reg [7:0] dev_en_q;
  wire tick;
  wire cnt_lat = mode_q[`SCLT_MODE_CNT_LAT];
  wire stat_lat = mode_q[`SCLT_MODE_STAT_LAT];

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_q <= `SCLT_RST_BYTE;
      dev_en_q <= `SCLT_RST_BYTE;
    end else begin
      if (WR && ADDR == `SCLT_ADR_MODE) begin
        mode_q <= WDATA;
      end
      if (WR && ADDR == `SCLT_ADR_DEV_SUM_EN) begin
        dev_en_q <= WDATA;
      end
    end
  end

  sclt_onesec #(
    .DIV(DIV)
  ) u_onesec (
    .clk(MCLK),
    .rst_n(RSTN),
    .sec_out_mode(mode_q[`SCLT_MODE_SEC_OUT]),
    .ref_in(FRAME_REF),
    .pin_in(ONESEC_I),
    .tick_q(tick),
    .pin_o_q(ONESEC_O),
    .pin_oe_q(ONESEC_OE)
  );

  // ****************************************
  // per-port flags, counters and summaries
  // ****************************************
  // the inverse-multiplexing block has no input into this tree
  wire [8*NPORT-1:0] sum_flat;
  wire [8*NPORT-1:0] sum_en_flat;
  wire [8*NPORT-1:0] rx_flag_flat;
  wire [8*NPORT-1:0] tx_flag_flat;
  wire [8*NPORT-1:0] rx_en_flat;
  wire [8*NPORT-1:0] tx_en_flat;
  wire [8*NPORT-1:0] cnt_lo_flat;
  wire [8*NPORT-1:0] cnt_hi_flat;
  wire [8*NPORT-1:0] stat_flat;
  wire [NPORT-1:0] port_bits;

  genvar i;
  generate
    for (i = 0; i < NPORT; i = i + 1) begin : g_port
      localparam [2:0] PI = i;
      reg [7:0] rx_prev_q;
      reg [7:0] tx_prev_q;
      reg ext_prev_q;
      reg [7:0] rx_flag_q;
      reg [7:0] tx_flag_q;
      reg [7:0] rx_en_q;
      reg [7:0] tx_en_q;
      reg [7:0] sum_en_q;
      reg ext_flag_q;
      reg sec_flag_q;
      // wraps rather than saturates; sized for one second of cells
      reg [CNT_W-1:0] cnt_q;
      reg [CNT_W-1:0] lat_q;
      reg [7:0] hold_q;
      reg [7:0] stat_q;
      reg [CNT_W-1:0] cnt_d;
      reg [CNT_W-1:0] lat_d;
      reg [7:0] hold_d;
      reg [7:0] stat_d;
      wire [7:0] rx_now = RX_STATUS[8*i +: 8];
      wire [7:0] tx_now = TX_STATUS[8*i +: 8];
      // read strobes carry the clear-on-read side effects
      wire rd_sum = RD && port_reg(ADDR, PI, `SCLT_OFF_SUM);
      wire rd_rx = RD && port_reg(ADDR, PI, `SCLT_OFF_RX_FLAGS);
      wire rd_tx = RD && port_reg(ADDR, PI, `SCLT_OFF_TX_FLAGS);
      wire rd_lo = RD && port_reg(ADDR, PI, `SCLT_OFF_CNT_LO);
      // enables are plain read-write; only the flags and the counters clear on read
      wire wr_rx_en = WR && port_reg(ADDR, PI, `SCLT_OFF_RX_EN);
      wire wr_tx_en = WR && port_reg(ADDR, PI, `SCLT_OFF_TX_EN);
      wire wr_sum_en = WR && port_reg(ADDR, PI, `SCLT_OFF_SUM_EN);
      // rising edges always count, falling ones only on dual bits
      wire [7:0] rx_set = (rx_now & ~rx_prev_q) |
                          ((rx_now ^ rx_prev_q) & `SCLT_DUAL_RX);
      wire [7:0] tx_set = (tx_now & ~tx_prev_q) |
                          ((tx_now ^ tx_prev_q) & `SCLT_DUAL_TX);
      wire ext_set = EXT_IRQ[i] & ~ext_prev_q;
      wire [CNT_W-1:0] evt = {{(CNT_W-1){1'b0}}, CELL_EVT[i]};
      wire [7:0] sum_vec;

      // edge history for the event detectors
      always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
          rx_prev_q <= `SCLT_RST_BYTE;
          tx_prev_q <= `SCLT_RST_BYTE;
          ext_prev_q <= 1'b0;
        end else begin
          rx_prev_q <= rx_now;
          tx_prev_q <= tx_now;
          ext_prev_q <= EXT_IRQ[i];
        end
      end

      always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
          rx_flag_q <= `SCLT_RST_BYTE;
          tx_flag_q <= `SCLT_RST_BYTE;
          ext_flag_q <= 1'b0;
          sec_flag_q <= 1'b0;
        end else begin
          // whole register clears on read; a new event still wins
          rx_flag_q <= (rd_rx ? `SCLT_RST_BYTE : rx_flag_q) | rx_set;
          tx_flag_q <= (rd_tx ? `SCLT_RST_BYTE : tx_flag_q) | tx_set;
          ext_flag_q <= (ext_flag_q & ~rd_sum) | ext_set;
          sec_flag_q <= (sec_flag_q & ~rd_sum) | tick;
        end
      end

      // enable masks, written by the host only
      always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
          rx_en_q <= `SCLT_RST_BYTE;
          tx_en_q <= `SCLT_RST_BYTE;
          sum_en_q <= `SCLT_RST_BYTE;
        end else begin
          if (wr_rx_en) begin
            rx_en_q <= WDATA;
          end
          if (wr_tx_en) begin
            tx_en_q <= WDATA;
          end
          if (wr_sum_en) begin
            sum_en_q <= WDATA;
          end
        end
      end

      // counter, latch and high-byte hold: next values
      always @* begin
        cnt_d = cnt_q + evt;
        lat_d = lat_q;
        hold_d = hold_q;
        stat_d = stat_q;
        if (tick && cnt_lat) begin
          // move and clear in one step; an event this cycle is kept
          lat_d = cnt_q;
          cnt_d = evt;
        end else if (rd_lo && cnt_lat) begin
          lat_d = {CNT_W{1'b0}};
        end else if (rd_lo) begin
          cnt_d = evt;
        end
        if (rd_lo) begin
          // freeze the high byte at the instant of the low read
          hold_d = cnt_lat ? lat_q[CNT_W-1:8] : cnt_q[CNT_W-1:8];
        end
        if (tick) begin
          stat_d = rx_now;
        end
      end

      always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
          cnt_q <= {CNT_W{1'b0}};
          lat_q <= {CNT_W{1'b0}};
          hold_q <= `SCLT_RST_BYTE;
          stat_q <= `SCLT_RST_BYTE;
        end else begin
          cnt_q <= cnt_d;
          lat_q <= lat_d;
          hold_q <= hold_d;
          stat_q <= stat_d;
        end
      end

      // enabled flags collapse into the summary bits
      assign sum_vec[`SCLT_SUM_RX] = |(rx_flag_q & rx_en_q);
      assign sum_vec[`SCLT_SUM_TX] = |(tx_flag_q & tx_en_q);
      assign sum_vec[`SCLT_SUM_EXT] = ext_flag_q;
      assign sum_vec[`SCLT_SUM_SEC] = sec_flag_q;
      assign sum_vec[7:4] = 4'h0;
      // live OR, so the port bit drops only when its summary is clear
      assign port_bits[i] = |(sum_vec & sum_en_q);

      assign sum_flat[8*i +: 8] = sum_vec;
      assign sum_en_flat[8*i +: 8] = sum_en_q;
      assign rx_flag_flat[8*i +: 8] = rx_flag_q;
      assign tx_flag_flat[8*i +: 8] = tx_flag_q;
      assign rx_en_flat[8*i +: 8] = rx_en_q;
      assign tx_en_flat[8*i +: 8] = tx_en_q;
      assign cnt_lo_flat[8*i +: 8] = cnt_lat ? lat_q[7:0] : cnt_q[7:0];
      // high byte only meaningful after the low byte was read
      assign cnt_hi_flat[8*i +: 8] = hold_q;
      assign stat_flat[8*i +: 8] = stat_lat ? stat_q : rx_now;
    end
  endgenerate

  // ****************************************
  // device summary and host interrupt pin
  // ****************************************
  // the 3-bit port field limits the tree to eight ports
  wire [7:0] dev_sum;

  generate
    if (NPORT < 8) begin : g_dev_pad
      assign dev_sum = {{(8-NPORT){1'b0}}, port_bits};
    end else begin : g_dev_full
      assign dev_sum = port_bits[7:0];
    end
  endgenerate

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      HOST_IRQ_N <= 1'b1;
    end else begin
      // registered so the pin is glitch-free; costs one clock of delay
      HOST_IRQ_N <= ~(mode_q[`SCLT_MODE_IRQ_EN] &
                      (|(dev_sum & dev_en_q)));
    end
  end

  // ****************************************
  // read path
  // ****************************************
  reg [7:0] rd_d;

  always @* begin
    rd_d = `SCLT_RST_BYTE;
    if (ADDR[`SCLT_DEV_SPACE_BIT]) begin
      case (ADDR)
        `SCLT_ADR_MODE: rd_d = mode_q;
        `SCLT_ADR_DEV_SUM: rd_d = dev_sum;
        `SCLT_ADR_DEV_SUM_EN: rd_d = dev_en_q;
        default: rd_d = `SCLT_RST_BYTE;
      endcase
    end else begin
      case (off)
        `SCLT_OFF_SUM: rd_d = sum_flat[base +: 8];
        `SCLT_OFF_SUM_EN: rd_d = sum_en_flat[base +: 8];
        `SCLT_OFF_RX_FLAGS: rd_d = rx_flag_flat[base +: 8];
        `SCLT_OFF_TX_FLAGS: rd_d = tx_flag_flat[base +: 8];
        `SCLT_OFF_RX_EN: rd_d = rx_en_flat[base +: 8];
        `SCLT_OFF_TX_EN: rd_d = tx_en_flat[base +: 8];
        `SCLT_OFF_CNT_LO: rd_d = cnt_lo_flat[base +: 8];
        `SCLT_OFF_CNT_HI: rd_d = cnt_hi_flat[base +: 8];
        `SCLT_OFF_STATUS: rd_d = stat_flat[base +: 8];
        default: rd_d = `SCLT_RST_BYTE;
      endcase
    end
  end

  // all registers are one byte; data holds until the next read
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= `SCLT_RST_BYTE;
    end else if (RD) begin
      RDATA <= rd_d;
    end
  end
endmodule // sclt_irq_tree
`default_nettype wire

/* File: core/sclt_onesec.v */
/*
 one-second tick source: divides the 8 kHz reference or detects the
 rising edge of the one-second pin. assumes both inputs are synchronous
 to the register clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sclt_map.vh"
module sclt_onesec #(
  parameter DIV = `SCLT_DIV_COUNT
) (
  input wire clk,
  input wire rst_n,
  input wire sec_out_mode,
  input wire ref_in,
  input wire pin_in,
  output reg tick_q,
  output reg pin_o_q,
  output reg pin_oe_q
);
  // ****************************************
  // edge detection and divider
  // ****************************************
  reg ref_prev_q;
  reg pin_prev_q;
  reg [`SCLT_DIV_W-1:0] div_q;
  wire ref_rise = ref_in & ~ref_prev_q;
  wire pin_rise = pin_in & ~pin_prev_q;
  wire wrap = ref_rise && (div_q == DIV - 1);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
      div_q <= {`SCLT_DIV_W{1'b0}};
      tick_q <= 1'b0;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_in;
      pin_prev_q <= pin_in;
      pin_oe_q <= sec_out_mode;
      if (wrap) begin
        div_q <= {`SCLT_DIV_W{1'b0}};
      end else if (ref_rise) begin
        div_q <= div_q + 1'b1;
      end
      // output mode: one clock high per 8000 reference edges
      pin_o_q <= sec_out_mode & wrap;
      // input mode: latch on the pin's rising edge
      tick_q <= sec_out_mode ? wrap : pin_rise;
    end
  end
endmodule // sclt_onesec
`default_nettype wire

/* File: dv/sclt_host_bfm.sv */
/*
 host side model: byte-wide register reads and writes with one-cycle
 strobes. assumes the caller samples the read data after rd_reg returns.
*/
`timescale 1ns/10ps
`default_nettype none
module sclt_host_bfm (
  input wire logic mclk,
  output logic [9:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  // ****************
  // bus cycles
  // ****************
  initial begin
    addr = 10'h000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // an idle cycle follows every strobe, so strobes never merge
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd_reg(input logic [9:0] a);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    @(negedge mclk);
  endtask
endmodule // sclt_host_bfm
`default_nettype wire

/* File: dv/sclt_irq_tree_sva.sv */
/*
 assertions on the irq tree ports: read answers, pin gating and the
 one-second output. assumes sclt_map.vh on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sclt_map.vh"
module sclt_irq_tree_sva (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic ONESEC_O,
  input wire logic ONESEC_OE,
  input wire logic HOST_IRQ_N
);
  // ****************
  // properties
  // ****************
  localparam logic [9:0] MODE_A = `SCLT_ADR_MODE;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  wire mode_wr = WR && ADDR == MODE_A;
  a_oe_on_write:
    assert property (mode_wr && WDATA[0] |-> ##2 ONESEC_OE)
    else $error("pin not driven after output mode write");
  a_oe_off_write:
    assert property (mode_wr && !WDATA[0] |-> ##2 !ONESEC_OE)
    else $error("pin still driven after input mode write");
  a_out_needs_oe:
    assert property (ONESEC_O |-> ONESEC_OE)
    else $error("pulse shown while pin not driven");
  // the reference needs at least two cycles per edge, so gaps are long
  a_pulse_gap:
    assert property (ONESEC_O |=> !ONESEC_O [*4])
    else $error("one-second pulses too close");
  a_irq_gate_off:
    assert property (mode_wr && !WDATA[3] |-> ##2 HOST_IRQ_N)
    else $error("irq pin active while pin disabled");
  a_irq_rise_cause:
    assert property ($rose(HOST_IRQ_N) |->
      $past(RD) || $past(RD, 2) || $past(WR) || $past(WR, 2))
    else $error("irq released without host access");
  a_rdata_holds:
    assert property ($changed(RDATA) |-> $past(RD))
    else $error("read data changed without a read");
  a_unmapped_zero:
    assert property (RD && ADDR == 10'h208 |-> ##1 RDATA == 8'h00)
    else $error("unmapped read not zero");
  c_irq_low: cover property ($fell(HOST_IRQ_N));
  c_pulse: cover property (ONESEC_O);
  c_flag_read: cover property (RD && ADDR[5:0] == `SCLT_OFF_TX_FLAGS);
endmodule // sclt_irq_tree_sva
bind sclt_irq_tree sclt_irq_tree_sva sclt_irq_tree_sva_inst (
  .MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .ONESEC_O(ONESEC_O), .ONESEC_OE(ONESEC_OE),
  .HOST_IRQ_N(HOST_IRQ_N));
`default_nettype wire

/* File: dv/sclt_irq_tree_test.sv */
/*
 bench: counter, one-second latch and interrupt tree sequences on port 0.
 assumes sclt_map.vh on the include path and the host model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sclt_map.vh"
module sclt_irq_tree_test;
  // ****************
  // setup
  // ****************
  localparam logic [9:0] SUM = {4'h0, `SCLT_OFF_SUM};
  localparam logic [9:0] SEN = {4'h0, `SCLT_OFF_SUM_EN};
  localparam logic [9:0] RXF = {4'h0, `SCLT_OFF_RX_FLAGS};
  localparam logic [9:0] TXF = {4'h0, `SCLT_OFF_TX_FLAGS};
  localparam logic [9:0] RXE = {4'h0, `SCLT_OFF_RX_EN};
  localparam logic [9:0] TXE = {4'h0, `SCLT_OFF_TX_EN};
  localparam logic [9:0] LO = {4'h0, `SCLT_OFF_CNT_LO};
  localparam logic [9:0] HI = {4'h0, `SCLT_OFF_CNT_HI};
  localparam logic [9:0] ST = {4'h0, `SCLT_OFF_STATUS};
  logic MCLK = 1'b0, RSTN = 1'b0, FRAME_REF = 1'b0, sec_drv = 1'b0;
  logic [63:0] RX_STATUS = '0, TX_STATUS = '0;
  logic [7:0] EXT_IRQ = '0, CELL_EVT = '0, pulses = '0;
  wire [9:0] ADDR;
  wire [7:0] WDATA, RDATA;
  wire WR, RD, ONESEC_O, ONESEC_OE, HOST_IRQ_N;
  wire ONESEC_I = ONESEC_OE ? ONESEC_O : sec_drv;
  int err_count = 0, tests_run = 0, cyc = 0;
  // short divider keeps the output-mode run brief
  sclt_irq_tree #(.DIV(4)) sclt_irq_tree_inst (.MCLK(MCLK), .RSTN(RSTN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RX_STATUS(RX_STATUS), .TX_STATUS(TX_STATUS), .EXT_IRQ(EXT_IRQ),
    .CELL_EVT(CELL_EVT), .FRAME_REF(FRAME_REF), .ONESEC_I(ONESEC_I),
    .ONESEC_O(ONESEC_O), .ONESEC_OE(ONESEC_OE), .HOST_IRQ_N(HOST_IRQ_N));
  sclt_host_bfm sclt_host_bfm_inst (.mclk(MCLK), .addr(ADDR),
    .wdata(WDATA), .wr(WR), .rd(RD));
  always #50 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    if (ONESEC_O === 1'b1) pulses <= pulses + 8'h01;
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      complete_run;
    end
  end
  // ****************
  // tasks
  // ****************
  task complete_run;
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: data %h expected %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: pin %b expected %b", $time, g, e);
    end
  endtask
  task rc(input logic [9:0] a, input logic [7:0] e);
    sclt_host_bfm_inst.rd_reg(a);
    chk8(RDATA, e);
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    sclt_host_bfm_inst.wr_reg(a, d);
  endtask
  task idle(input int k);
    repeat (k) @(negedge MCLK);
  endtask
  task evt(input int k);
    repeat (k) begin
      idle(1);
      CELL_EVT[0] = 1'b1;
      idle(1);
      CELL_EVT[0] = 1'b0;
    end
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    idle(8);
    RSTN = 1'b1;
    chk1(HOST_IRQ_N, 1'b1);
    chk1(ONESEC_OE, 1'b0);
    rc(`SCLT_ADR_MODE, 8'h00);
    rc(10'h208, 8'h00);
    evt(300);
    rc(LO, 8'h2C);
    evt(5);
    rc(HI, 8'h01);
    rc(LO, 8'h05);
    RX_STATUS[7:0] = 8'h05;
    wr(`SCLT_ADR_MODE, 8'h30);
    evt(7);
    sec_drv = 1'b1;
    idle(2);
    sec_drv = 1'b0;
    idle(2);
    RX_STATUS[7:0] = 8'h0A;
    evt(2);
    rc(ST, 8'h05);
    rc(LO, 8'h07);
    rc(LO, 8'h00);
    rc(SUM, 8'h08);
    rc(SUM, 8'h00);
    rc(RXF, 8'h0F);
    rc(RXF, 8'h00);
    RX_STATUS[7:0] = 8'h00;
    wr(`SCLT_ADR_MODE, 8'h00);
    rc(LO, 8'h02);
    rc(ST, 8'h00);
    wr(TXE, 8'hFF);
    wr(RXE, 8'h80);
    wr(SEN, 8'h0F);
    wr(`SCLT_ADR_DEV_SUM_EN, 8'h01);
    wr(`SCLT_ADR_MODE, 8'h08);
    TX_STATUS[7] = 1'b1;
    idle(3);
    chk1(HOST_IRQ_N, 1'b0);
    rc(`SCLT_ADR_DEV_SUM, 8'h01);
    rc(SUM, 8'h02);
    TX_STATUS[7] = 1'b0;
    rc(TXF, 8'h80);
    rc(TXF, 8'h00);
    rc(`SCLT_ADR_DEV_SUM, 8'h00);
    rc(SUM, 8'h00);
    chk1(HOST_IRQ_N, 1'b1);
    RX_STATUS[7] = 1'b1;
    idle(3);
    chk1(HOST_IRQ_N, 1'b0);
    rc(RXF, 8'h80);
    RX_STATUS[7] = 1'b0;
    idle(3);
    rc(RXF, 8'h80);
    rc(RXF, 8'h00);
    wr(TXE, 8'h00);
    TX_STATUS[7] = 1'b1;
    idle(3);
    chk1(HOST_IRQ_N, 1'b1);
    rc(SUM, 8'h00);
    rc(TXF, 8'h80);
    EXT_IRQ[0] = 1'b1;
    idle(3);
    chk1(HOST_IRQ_N, 1'b0);
    wr(`SCLT_ADR_MODE, 8'h00);
    chk1(HOST_IRQ_N, 1'b1);
    rc(SUM, 8'h04);
    rc(SUM, 8'h00);
    wr(`SCLT_ADR_MODE, 8'h01);
    chk1(ONESEC_OE, 1'b1);
    repeat (8) begin
      idle(1);
      FRAME_REF = 1'b1;
      idle(1);
      FRAME_REF = 1'b0;
    end
    idle(3);
    chk8(pulses, 8'h02);
    rc(10'h040, 8'h08);
    rc(10'h040, 8'h00);
    wr(`SCLT_ADR_MODE, 8'h00);
    chk1(ONESEC_OE, 1'b0);
    complete_run;
  end
endmodule // sclt_irq_tree_test
`default_nettype wire

/* File: inc/sclt_map.vh */
/*
 map of the statistics counter, one-second latch and interrupt tree.
 assumes the 10-bit register address of the 8-bit host bus.
*/
`ifndef SCLT_MAP_VH
`define SCLT_MAP_VH
// ****************************************
// port register offsets (6-bit)
// ****************************************
`define SCLT_OFF_SUM 6'h00
`define SCLT_OFF_SUM_EN 6'h01
`define SCLT_OFF_RX_FLAGS 6'h0D
`define SCLT_OFF_TX_FLAGS 6'h2C
`define SCLT_OFF_RX_EN 6'h30
`define SCLT_OFF_TX_EN 6'h31
`define SCLT_OFF_CNT_LO 6'h32
`define SCLT_OFF_CNT_HI 6'h33
`define SCLT_OFF_STATUS 6'h34
// ****************************************
// device registers (10-bit)
// ****************************************
`define SCLT_ADR_MODE 10'h202
`define SCLT_ADR_DEV_SUM 10'h204
`define SCLT_ADR_DEV_SUM_EN 10'h205
`define SCLT_DEV_SPACE_BIT 9
// ****************************************
// fields
// ****************************************
`define SCLT_MODE_SEC_OUT 0
`define SCLT_MODE_IRQ_EN 3
`define SCLT_MODE_CNT_LAT 4
`define SCLT_MODE_STAT_LAT 5
`define SCLT_SUM_RX 0
`define SCLT_SUM_TX 1
`define SCLT_SUM_EXT 2
`define SCLT_SUM_SEC 3
`define SCLT_DUAL_RX 8'h80
`define SCLT_DUAL_TX 8'h00
// ****************************************
// reset values and counts
// ****************************************
`define SCLT_RST_BYTE 8'h00
`define SCLT_DIV_COUNT 8000
`define SCLT_DIV_W 13
`define SCLT_CNT_W 16
`endif
